// File: core/sar_ctrl_pkg.sv
/*
  constants shared by the converter control block: sizes, bus layout, timing.
  assumes one 200 MHz converter clock feeding every file.
*/
package sar_ctrl_pkg;

  // code and bus widths, sequencer stages, divider width
  localparam int unsigned RESULT_BITS      = 10;
  localparam int unsigned BUS_BITS         = 8;
  localparam int unsigned SEQ_STAGES       = 8;
  localparam int unsigned PHASE_BITS       = 3;

  // second byte layout: bits 1..0 on the two top lines, rest zero
  localparam int unsigned LOW_BYTE_TOP     = 7;
  localparam int unsigned LOW_BYTE_PAD     = 6;
  localparam logic [5:0]  LOW_BYTE_ZERO    = 6'h00;

  // reset, start and release values
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 10'h000;
  localparam logic [RESULT_BITS-1:0] MARKER_FIRST = 10'h200;
  localparam logic [SEQ_STAGES-1:0]  SEQ_FIRST    = 8'h01;
  localparam logic [SEQ_STAGES-1:0]  SEQ_RESET    = 8'h00;
  localparam logic [BUS_BITS-1:0]    BUS_RESET    = 8'h00;
  localparam logic [PHASE_BITS-1:0]  PHASE_RELEASE = 3'h7;

  // timing
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned SET_PULSE_PS     = 400000;
  localparam int unsigned SET_PULSE_CYCLES = (SET_PULSE_PS / CLK_PERIOD_PS < 1) ? 1
                                           : SET_PULSE_PS / CLK_PERIOD_PS;
  localparam int unsigned SET_CNT_BITS     = $clog2(SET_PULSE_CYCLES + 1);

endpackage

// File: core/pin_sync.sv
/*
  two-flop synchroniser for a group of pin inputs, one chain per bit.
  assumes the pins are asynchronous to i_ref_clk; reset value is a constant.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned    WIDTH     = 1,
  parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic first_stage;
      logic second_stage;
      // first stage is read by the second flop only
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          first_stage  <= RST_VALUE[g];
          second_stage <= RST_VALUE[g];
        end else begin
          first_stage  <= i_pin[g];
          second_stage <= first_stage;
        end
      end
      assign o_sync[g] = second_stage;
    end
  endgenerate

endmodule

// File: core/set_one_shot.sv
/*
  retriggerable one-shot: a trigger pulse starts a fixed-length high output.
  assumes a single-cycle trigger from logic on the same clock.
*/
`timescale 1ns/100ps
module set_one_shot
  import sar_ctrl_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = sar_ctrl_pkg::SET_PULSE_CYCLES
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_trigger,
  output logic      o_pulse
);
  import sar_ctrl_pkg::*;

  localparam int unsigned CNT_BITS = $clog2(PULSE_CYCLES + 1);
  localparam logic [CNT_BITS-1:0] CNT_LOAD = CNT_BITS'(PULSE_CYCLES);

  logic [CNT_BITS-1:0] remaining;
  logic [CNT_BITS-1:0] next_remaining;

  always_comb begin
    next_remaining = remaining;
    if (i_trigger) begin
      next_remaining = CNT_LOAD;
    end else if (remaining != '0) begin
      next_remaining = remaining - CNT_BITS'(1);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      remaining <= '0;
    end else begin
      remaining <= next_remaining;
    end
  end

  // output is high for exactly PULSE_CYCLES cycles after the trigger
  assign o_pulse = (remaining != '0);

endmodule

// File: core/sar_adc_bus_control.sv
/*
  control logic of a 10-bit successive approximation converter with an
  8-bit microprocessor-style port: start/abort, 80-clock search, output
  latch, completion flag and two-byte left-justified read-out.
  assumes an external ladder/comparator: o_trial_code drives the ladder and
  i_comp_above answers whether the input difference is at or above it.
  bus strobes and analog flags are asynchronous pins, synchronised here.
*/
`timescale 1ns/100ps

module sar_adc_bus_control
  import sar_ctrl_pkg::*;
(
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_rst,
  input  wire logic                              i_cs_n,
  input  wire logic                              i_wr_n,
  input  wire logic                              i_rd_n,
  input  wire logic                              i_comp_above,
  input  wire logic                              i_neg_at_or_above,
  output logic      [sar_ctrl_pkg::RESULT_BITS-1:0] o_trial_code,
  output logic      [sar_ctrl_pkg::BUS_BITS-1:0]    o_bus_data,
  output logic      [sar_ctrl_pkg::BUS_BITS-1:0]    o_bus_oe_n,
  output logic                                   o_conversion_done_n
);
  import sar_ctrl_pkg::*;

  typedef enum logic [2:0] {
    st_idle    = 3'b001,
    st_hold    = 3'b010,
    st_convert = 3'b100
  } conv_state_t;

  // synchronised pins: cs, wr, rd, comparator, negative-input flag
  logic [4:0] pins_sync;
  logic       cs_n_s;
  logic       wr_n_s;
  logic       rd_n_s;
  logic       comp_above_s;
  logic       neg_above_s;

  pin_sync #(
    .WIDTH     (5),
    .RST_VALUE (5'h07)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_pin     ({i_neg_at_or_above, i_comp_above, i_rd_n, i_wr_n, i_cs_n}),
    .o_sync    (pins_sync)
  );

  assign cs_n_s       = pins_sync[0];
  assign wr_n_s       = pins_sync[1];
  assign rd_n_s       = pins_sync[2];
  assign comp_above_s = pins_sync[3];
  assign neg_above_s  = pins_sync[4];

  logic start_set;
  logic read_sel;
  assign start_set = ~cs_n_s & ~wr_n_s;
  assign read_sel  = ~cs_n_s & ~rd_n_s;

  // conversion state
  conv_state_t                   state;
  conv_state_t                   next_state;
  logic [PHASE_BITS-1:0]         phase;
  logic [PHASE_BITS-1:0]         next_phase;
  logic                          first_stage_flop;
  logic                          next_first_stage_flop;
  logic [SEQ_STAGES-1:0]         seq_ring;
  logic [SEQ_STAGES-1:0]         next_seq_ring;
  logic [RESULT_BITS-1:0]        bit_marker;
  logic [RESULT_BITS-1:0]        next_bit_marker;
  logic [RESULT_BITS-1:0]        approximation_register;
  logic [RESULT_BITS-1:0]        next_approximation_register;
  logic [RESULT_BITS-1:0]        out_latch;
  logic [RESULT_BITS-1:0]        next_out_latch;
  logic                          result_transfer;
  logic                          next_result_transfer;
  logic                          start_release_gate;
  logic [RESULT_BITS-1:0]        decided;

  // release pulse only on one phase of a free 3-bit divider, giving 1..8 clocks
  assign start_release_gate = (state == st_hold) & first_stage_flop &
                              (phase == PHASE_RELEASE);

  always_comb begin
    next_state                  = state;
    next_phase                  = phase + PHASE_BITS'(1);
    next_first_stage_flop       = first_stage_flop;
    next_seq_ring               = seq_ring;
    next_bit_marker             = bit_marker;
    next_approximation_register = approximation_register;
    next_out_latch              = out_latch;
    next_result_transfer        = 1'b0;
    decided                     = approximation_register;
    if (start_set) begin
      // start state is sticky, so a strobe sampled on one clock edge is never missed
      next_state                  = st_hold;
      next_seq_ring               = SEQ_RESET;
      next_bit_marker             = RESULT_RESET;
      next_approximation_register = RESULT_RESET;
      next_first_stage_flop       = 1'b1;
    end else begin
      unique case (state)
        st_idle: begin
          next_first_stage_flop = 1'b0;
        end
        st_hold: begin
          // held here while both strobes low; release needs one of them high
          next_first_stage_flop = 1'b1;
          if (start_release_gate) begin
            next_state            = st_convert;
            next_first_stage_flop = 1'b0;
            next_seq_ring         = SEQ_FIRST;
            next_bit_marker       = MARKER_FIRST;
          end
        end
        st_convert: begin
          next_seq_ring = {seq_ring[SEQ_STAGES-2:0], seq_ring[SEQ_STAGES-1]};
          if (seq_ring[0]) begin
            next_approximation_register = approximation_register | bit_marker;
          end
          if (seq_ring[SEQ_STAGES-1]) begin
            if (!comp_above_s) begin
              decided = approximation_register & ~bit_marker;
            end
            next_approximation_register = decided;
            next_bit_marker             = bit_marker >> 1;
            if (bit_marker[0]) begin
              // straight binary; forced to zero when inputs are reversed
              next_out_latch       = neg_above_s ? RESULT_RESET : decided;
              next_result_transfer = 1'b1;
              next_state           = st_idle;
              next_seq_ring        = SEQ_RESET;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state                  <= st_idle;
      phase                  <= '0;
      first_stage_flop       <= 1'b0;
      seq_ring               <= SEQ_RESET;
      bit_marker             <= RESULT_RESET;
      approximation_register <= RESULT_RESET;
      out_latch              <= RESULT_RESET;
      result_transfer        <= 1'b0;
    end else begin
      state                  <= next_state;
      phase                  <= next_phase;
      first_stage_flop       <= next_first_stage_flop;
      seq_ring               <= next_seq_ring;
      bit_marker             <= next_bit_marker;
      approximation_register <= next_approximation_register;
      out_latch              <= next_out_latch;
      result_transfer        <= next_result_transfer;
    end
  end

  assign o_trial_code = approximation_register;

  // completion flag: one-shot fired on the falling edge of the transfer
  logic transfer_prev;
  logic transfer_fall;
  logic set_pulse;
  logic done_flag;
  logic next_done_flag;

  assign transfer_fall = transfer_prev & ~result_transfer;

  set_one_shot #(
    .PULSE_CYCLES (SET_PULSE_CYCLES)
  ) u_set_one_shot (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_trigger (transfer_fall),
    .o_pulse   (set_pulse)
  );

  always_comb begin
    next_done_flag = done_flag;
    if (start_set || read_sel) begin
      next_done_flag = 1'b0;
    end
    // set overrides a held clear, so a continuous read still sees the pulse
    if (set_pulse) begin
      next_done_flag = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      transfer_prev <= 1'b0;
      done_flag     <= 1'b0;
    end else begin
      transfer_prev <= result_transfer;
      done_flag     <= next_done_flag;
    end
  end

  // inverted flag feeds straight back to the start strobe in free-run
  assign o_conversion_done_n = ~done_flag;

  // read-out: byte pointer and bus drivers
  logic                byte_low;
  logic                next_byte_low;
  logic                read_prev;
  logic [BUS_BITS-1:0] bus_data;
  logic [BUS_BITS-1:0] next_bus_data;
  logic                bus_oe_n;
  logic                next_bus_oe_n;

  always_comb begin
    next_byte_low = byte_low;
    if (result_transfer) begin
      next_byte_low = 1'b0;
    end else if (read_prev && !read_sel) begin
      next_byte_low = ~byte_low;
    end
    if (byte_low) begin
      next_bus_data = {out_latch[1:0], LOW_BYTE_ZERO};
    end else begin
      next_bus_data = out_latch[RESULT_BITS-1:2];
    end
    next_bus_oe_n = ~read_sel;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      byte_low  <= 1'b0;
      read_prev <= 1'b0;
      bus_data  <= BUS_RESET;
      bus_oe_n  <= 1'b1;
    end else begin
      byte_low  <= next_byte_low;
      read_prev <= read_sel;
      bus_data  <= next_bus_data;
      bus_oe_n  <= next_bus_oe_n;
    end
  end

  assign o_bus_data = bus_data;
  assign o_bus_oe_n = {BUS_BITS{bus_oe_n}};

endmodule

// File: dv/sar_ctrl_assertions.sv
/* port checker for the converter control block.
   assumes a bind onto sar_adc_bus_control and its single clock. */
`timescale 1ns/100ps
module sar_ctrl_assertions
  import sar_ctrl_pkg::*;
(
  input wire logic                   i_ref_clk,
  input wire logic                   i_rst,
  input wire logic                   i_cs_n,
  input wire logic                   i_wr_n,
  input wire logic                   i_rd_n,
  input wire logic                   i_comp_above,
  input wire logic                   i_neg_at_or_above,
  input wire logic [RESULT_BITS-1:0] o_trial_code,
  input wire logic [BUS_BITS-1:0]    o_bus_data,
  input wire logic [BUS_BITS-1:0]    o_bus_oe_n,
  input wire logic                   o_conversion_done_n
);
  // cycles the flag has been low, saturating
  logic [7:0] low_cnt;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) low_cnt <= 8'h00;
    else if (o_conversion_done_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // five samples cover the two synchroniser flops
  sequence start_held; (!i_cs_n && !i_wr_n)[*5]; endsequence
  sequence start_lift; (i_cs_n || i_wr_n)[*2]; endsequence
  sequence read_held; (!i_cs_n && !i_rd_n)[*5]; endsequence
  a_hold_reset: assert property (start_held |-> o_trial_code == 10'h000)
    else $error("trial code not cleared while start held");
  a_start_window: assert property (start_held ##1 start_lift |-> ##[0:12] o_trial_code == 10'h200)
    else $error("conversion did not begin msb first in time");
  a_bit_spacing: assert property (($changed(o_trial_code)
      && ((o_trial_code & ~$past(o_trial_code)) != 10'h000))
      |=> ($stable(o_trial_code) || !i_wr_n)[*6])
    else $error("bit decision shorter than eight clocks");
  a_pulse_width: assert property ($rose(o_conversion_done_n) |-> low_cnt >= 8'h4F)
    else $error("completion low pulse too short");
  a_flag_clear: assert property ((!i_cs_n && (!i_wr_n || !i_rd_n))[*5] ##0 (low_cnt > 8'h5A)
      |-> ##[0:2] o_conversion_done_n)
    else $error("completion flag not cleared");
  a_read_enable: assert property (read_held |-> o_bus_oe_n == 8'h00)
    else $error("bus not driven during read");
  a_bus_release: assert property ((i_cs_n || i_rd_n)[*5] |-> o_bus_oe_n == 8'hFF)
    else $error("bus driven outside read");
  a_oe_equal: assert property (o_bus_oe_n == 8'h00 || o_bus_oe_n == 8'hFF)
    else $error("bus enables differ between lines");
endmodule

bind sar_adc_bus_control sar_ctrl_assertions chk_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_cs_n(i_cs_n), .i_wr_n(i_wr_n), .i_rd_n(i_rd_n), .i_comp_above(i_comp_above),
  .i_neg_at_or_above(i_neg_at_or_above), .o_trial_code(o_trial_code),
  .o_bus_data(o_bus_data), .o_bus_oe_n(o_bus_oe_n), .o_conversion_done_n(o_conversion_done_n));

// File: dv/analog_front_model.sv
/* ladder comparator and input reversal flag of the analog side.
   assumes the bench gives the input level as a 10-bit code. */
`timescale 1ns/100ps
module analog_front_model (
  input  wire logic [9:0] i_trial_code,
  input  wire logic [9:0] i_level,
  input  wire logic       i_reversed,
  output logic            o_comp_above,
  output logic            o_neg_at_or_above
);
  // answers at once, well inside the synchroniser margin
  assign o_comp_above      = (i_level >= i_trial_code);
  assign o_neg_at_or_above = i_reversed;
endmodule

// File: dv/sar_adc_bus_control_tb.sv
/* self-checking bench for the converter control block.
   assumes the analog front model and the bound port checker. */
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module sar_adc_bus_control_tb;
  import sar_ctrl_pkg::*;
  logic                   ref_clk, rst, cs_n, wr_n, rd_n, comp_above, neg_flag, reversed;
  logic                   done_n, done_seen;
  logic [RESULT_BITS-1:0] trial_code, level, lv;
  logic [BUS_BITS-1:0]    bus_data, bus_oe_n, oe_prev, exp_b;
  logic [BUS_BITS-1:0]    exp_q[$];
  int                     err_total, checks_done, falls;
  sar_adc_bus_control dut_u (.i_ref_clk(ref_clk), .i_rst(rst), .i_cs_n(cs_n), .i_wr_n(wr_n),
    .i_rd_n(rd_n), .i_comp_above(comp_above), .i_neg_at_or_above(neg_flag),
    .o_trial_code(trial_code), .o_bus_data(bus_data), .o_bus_oe_n(bus_oe_n),
    .o_conversion_done_n(done_n));
  analog_front_model afe_u (.i_trial_code(trial_code), .i_level(level), .i_reversed(reversed),
    .o_comp_above(comp_above), .o_neg_at_or_above(neg_flag));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_level(input logic want, input int limit);
    int k;
    for (k = 0; k < limit && done_n !== want; k++) tick(1);
    if (k == limit) begin
      err_total++;
      report_and_stop();
    end
  endtask
  // select brackets the strobe so the strobe width rules
  task automatic start_pulse();
    cs_n <= 1'b0;
    tick(1);
    wr_n <= 1'b0;
    tick(5);
    wr_n <= 1'b1;
    tick(1);
    cs_n <= 1'b1;
  endtask
  task automatic read_byte(input logic [7:0] e);
    exp_q.push_back(e);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    tick(6);
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    tick(6);
  endtask
  // third read wraps back to the high byte
  task automatic convert(input logic [9:0] v, input logic rv, input logic [9:0] code);
    level <= v;
    reversed <= rv;
    start_pulse();
    wait_level(1'b0, 400);
    read_byte(code[9:2]);
    read_byte({code[1:0], LOW_BYTE_ZERO});
    read_byte(code[9:2]);
    // let the set pulse run out, else the next start cannot clear the flag
    tick(50);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // sampled mid-cycle so design updates have landed
  always @(negedge ref_clk) begin
    if (oe_prev === 8'hFF && bus_oe_n === 8'h00) begin
      exp_b = exp_q.pop_front();
      `CHK(bus_data, exp_b)
    end
    if (done_seen === 1'b1 && done_n === 1'b0) falls++;
    oe_prev <= bus_oe_n;
    done_seen <= done_n;
  end
  initial begin
    rst = 1'b1; cs_n = 1'b1; wr_n = 1'b1; rd_n = 1'b1; level = '0; reversed = 1'b0;
    oe_prev = 8'hFF; done_seen = 1'b1; err_total = 0; checks_done = 0; falls = 0;
    void'($urandom(32'h62408a73));
    tick(3);
    rst <= 1'b0;
    tick(2);
    `CHK(bus_oe_n, 8'hFF)
    `CHK(done_n, 1'b1)
    convert(10'h3FF, 1'b0, 10'h3FF);
    convert(10'h000, 1'b0, 10'h000);
    for (int i = 0; i < 4; i++) begin
      lv = 10'($urandom);
      convert(lv, 1'b0, lv);
    end
    convert(10'($urandom), 1'b1, 10'h000);
    level <= 10'h155;
    start_pulse();
    tick(20 + ($urandom % 40));
    lv = 10'($urandom);
    convert(lv, 1'b0, lv);
    // read held through a whole conversion: pointer starts on the low byte, the transfer moves it to the high byte
    exp_q.push_back({lv[1:0], LOW_BYTE_ZERO});
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    wr_n <= 1'b0;
    tick(5);
    wr_n <= 1'b1;
    wait_level(1'b0, 400);
    for (falls = 0; falls < 200 && done_n !== 1'b1; falls++) tick(1);
    `CHK(falls >= 79 && falls < 90, 1'b1)
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    tick(6);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    tick(5);
    falls = 0;
    for (int i = 0; i < 700; i++) begin
      wr_n <= done_seen;
      tick(1);
    end
    `CHK(falls >= 3, 1'b1)
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule
